// ===== piso_shift_register_8bit.v
`timescale 1ns/10ps
`default_nettype none
`include "piso_regs.vh"
module piso_shift_register_8bit (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire load_n_i,
  input wire clk_a_i,
  input wire clk_b_i,
  input wire serial_in_i,
  input wire [`PISO_STAGES-1:0] par_i,
  output reg q_o,
  output reg q_n_o,
  output reg [`PISO_STAGES-1:0] stages_o,
  output reg shift_seen_o,
  input wire bit_ready_i,
  output reg bit_valid_o,
  output reg bit_o,
  output reg fifo_ready_o
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [11:0] sync1;
  reg [11:0] sync2;
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1 <= 12'h000;
      sync2 <= 12'h000;
    end
    else
    begin
      sync1 <= {load_n_i, clk_a_i, clk_b_i, serial_in_i, par_i};
      sync2 <= sync1;
    end
  end
  wire load_s;
  wire clk_a_s;
  wire clk_b_s;
  wire ser_s;
  wire [`PISO_STAGES-1:0] par_s;
  assign load_s = sync2[11];
  assign clk_a_s = sync2[10];
  assign clk_b_s = sync2[9];
  assign ser_s = sync2[8];
  assign par_s = sync2[7:0];
  ////////////////////////////////////////////////////////////////////
  // effective shift clock
  // or of clocks
  wire or_clk;
  assign or_clk = clk_a_s | clk_b_s;
  reg or_clk_d;
  wire shift_edge;
  assign shift_edge = or_clk && !or_clk_d && load_s;
  ////////////////////////////////////////////////////////////////////
  // stage register
  reg [`PISO_STAGES-1:0] stage;
  reg [`PISO_STAGES-1:0] next_stage;
  wire fifo_in_ready;
  always @*
  begin
    next_stage = stage;
    if (!load_s)
    begin
      next_stage = par_s;
    end
    else if (shift_edge)
    begin
      next_stage = {stage[`PISO_STAGES-2:0], ser_s};
    end
  end
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage <= 8'h00;
      or_clk_d <= 1'b0;
    end
    else
    begin
      or_clk_d <= or_clk;
      stage <= next_stage;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // outputs and shifted-out bit stream
  wire [`PISO_FIFO_WIDTH-1:0] fifo_data;
  wire fifo_valid;
  piso_fifo #(
    .WIDTH(`PISO_FIFO_WIDTH),
    .DEPTH(`PISO_FIFO_DEPTH),
    .AW(`PISO_FIFO_AW)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(stage[`PISO_STAGES-1]),
    .in_valid_i(shift_edge),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(bit_ready_i && !bit_valid_o)
  );
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q_o <= 1'b0;
      q_n_o <= 1'b1;
      stages_o <= 8'h00;
      shift_seen_o <= 1'b0;
      bit_valid_o <= 1'b0;
      bit_o <= 1'b0;
      fifo_ready_o <= 1'b1;
    end
    else
    begin
      q_o <= next_stage[`PISO_STAGES-1];
      q_n_o <= ~next_stage[`PISO_STAGES-1];
      stages_o <= next_stage;
      shift_seen_o <= shift_edge;
      fifo_ready_o <= fifo_in_ready;
      if (bit_valid_o)
      begin
        bit_valid_o <= 1'b0;
      end
      else if (fifo_valid && bit_ready_i)
      begin
        bit_valid_o <= 1'b1;
        bit_o <= fifo_data[0];
      end
    end
  end
endmodule // piso_shift_register_8bit
`default_nettype wire

// ===== piso_regs.vh
// How it works
// - load-select low copies parallel inputs, no clock
// - eight stages, all loaded from own input
// - shift mode rising edge captures serial input
// - shift only on rising edge in shift mode
// - each later stage takes preceding stage value
// - both clock inputs behave identically
// - either clock held high inhibits the other
// - contents held indefinitely, works down to DC
// - eighth stage drives true and inverted outputs
`ifndef PISO_REGS_VH
`define PISO_REGS_VH
`define PISO_STAGES 8
`define PISO_FIFO_WIDTH 1
`define PISO_FIFO_DEPTH 16
`define PISO_FIFO_AW 4
`endif

// ===== piso_fifo.v
`timescale 1ns/10ps
`default_nettype none
module piso_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop)
      begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end
      else if (pop && !push)
      begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // piso_fifo
`default_nettype wire

// ===== piso_checker.sv
`timescale 1ns/10ps
`default_nettype none
module piso_checker (
  input wire logic core_clk_i, rst_n_i, load_n_i, clk_a_i, clk_b_i,
  input wire logic q_o, q_n_o, shift_seen_o,
  input wire logic [7:0] par_i, stages_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_q_inverse: assert property (q_n_o == !q_o) else $error("q_n");
  a_q_last: assert property (q_o == stages_o[7]) else $error("q");
  a_shift_on: assert property (shift_seen_o |-> stages_o[7:1] == $past(stages_o[6:0]))
    else $error("move");
  a_load_copy: assert property ((!load_n_i && $stable(par_i))[*5] |-> stages_o == par_i)
    else $error("load");
  a_load_wins: assert property ((!load_n_i)[*5] |-> !shift_seen_o) else $error("lw");
  a_hold_a: assert property (clk_a_i[*6] |-> !shift_seen_o) else $error("ha");
  a_hold_b: assert property (clk_b_i[*6] |-> !shift_seen_o) else $error("hb");
  a_idle: assert property ((load_n_i && !clk_a_i && !clk_b_i)[*5] |=> $stable(stages_o))
    else $error("idle");
  c_load: cover property (!load_n_i ##6 load_n_i);
  c_shift: cover property (shift_seen_o && clk_b_i);
  c_block: cover property (clk_a_i && clk_b_i);
endmodule // piso_checker
bind piso_shift_register_8bit piso_checker u_chk (.*);
`default_nettype wire

// ===== piso_host.sv
`timescale 1ns/10ps
`default_nettype none
module piso_host (
  input wire logic core_clk_i, stall_i, bit_valid_i, bit_i,
  output var logic bit_ready_o,
  output var logic [15:0] bits_o,
  output var int n_bits_o
);
  int seed = 5;
  initial {bit_ready_o, bits_o, n_bits_o} = 0;
  // random stalls on the bit consumer
  always @(posedge core_clk_i)
  begin
    bit_ready_o <= !stall_i && 1'($random(seed));
    // valid is a one-cycle pulse; each pulse is one bit
    n_bits_o <= n_bits_o + int'(bit_valid_i);
    if (bit_valid_i)
      bits_o <= {bits_o[14:0], bit_i};
  end
endmodule // piso_host
`default_nettype wire

// ===== piso_shift_register_8bit_test.sv
`timescale 1ns/10ps
`default_nettype none
module piso_shift_register_8bit_test;
  logic core_clk_i = 0, rst_n_i = 0, load_n_i = 1, clk_a_i = 0, clk_b_i = 0;
  logic serial_in_i = 0, stall = 1, bit_ready_i, q_o, q_n_o, shift_seen_o;
  logic bit_valid_o, bit_o, fifo_ready_o;
  logic [7:0] par_i = 8'h00, stages_o, exp;
  logic [15:0] eb = 16'h0000, got_bits;
  int n_errors = 0, cmp_count = 0, cyc = 0, seed = 80130, nb;
  piso_shift_register_8bit dut (.*);
  piso_host host (.core_clk_i, .stall_i(stall), .bit_valid_i(bit_valid_o),
    .bit_i(bit_o), .bit_ready_o(bit_ready_i), .bits_o(got_bits), .n_bits_o(nb));
  task automatic chk(input logic [7:0] got, want);
    cmp_count++;
    if (got !== want)
    begin
      n_errors++;
      $display("unexpected %0t %h %h", $time, got, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic test_done(input int late);
    n_errors += late;
    $display("%0d compares %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
    forever #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
    if (++cyc == 2000)
      test_done(1);
  initial
  begin
    tick(8);
    rst_n_i <= 1;
    for (int i = 0; i < 6; i++)
    begin
      par_i <= i < 2 ? {8{i[0]}} : 8'($random(seed));
      {load_n_i, clk_a_i} <= {1'b0, i[0]};
      tick(6);
      chk(stages_o, par_i);
    end
    {exp, load_n_i, clk_a_i} <= {par_i, 2'h2};
    $display("load test end");
    for (int i = 0; i < 20; i++)
    begin
      serial_in_i <= 1'($random(seed));
      tick(6);
      {clk_a_i, clk_b_i} <= i[0] ? 2'h1 : 2'h2;
      tick(6);
      {exp, clk_a_i, clk_b_i} <= {exp[6:0], serial_in_i, 2'h0};
      if (i < 16)
        eb <= {eb[14:0], exp[7]};
      chk(stages_o, {exp[6:0], serial_in_i});
    end
    chk({7'h00, fifo_ready_o}, 8'h00);
    $display("shift test end");
    tick(6);
    clk_a_i <= 1;
    tick(6);
    {exp, clk_b_i} <= {exp[6:0], serial_in_i, 1'b1};
    tick(6);
    clk_a_i <= 0;
    tick(6);
    {clk_a_i, stall} <= 2'h2;
    tick(300);
    chk(stages_o, exp);
    chk({7'h00, fifo_ready_o}, 8'h01);
    chk(8'(nb), 8'h10);
    chk(got_bits[15:8], eb[15:8]);
    chk(got_bits[7:0], eb[7:0]);
    $display("inhibit test end");
    test_done(0);
  end
endmodule // piso_shift_register_8bit_test
`default_nettype wire
